// >>> bench/bus_side_model.sv
`timescale 1ns/1ps
module bus_side_model (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // Transfer handshake
  input  wire logic       xferReq,
  output logic            xferAck,
  // Requester pin and pacing set by the bench
  input  wire logic       pinPull,
  input  wire logic [1:0] ackWait,
  output logic            extRequestPin
);
  logic [1:0] waitCnt_q;

  // Pin idles high, requester pulls it low for falling edge or low level
  assign extRequestPin = ~pinPull;

  // ----------------------------------------------------------------
  // Acknowledge after ackWait held cycles; never two acks back to back
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      xferAck   <= 1'b0;
      waitCnt_q <= 2'h0;
    end else if (xferReq && !xferAck && waitCnt_q >= ackWait) begin
      xferAck   <= 1'b1;
      waitCnt_q <= 2'h0;
    end else begin
      xferAck   <= 1'b0;
      waitCnt_q <= (xferReq && waitCnt_q != 2'h3) ? waitCnt_q + 2'h1 : 2'h0;
    end
  end
endmodule

// >>> bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import dma_channel_pkg::*;
  logic        clock;
  logic        rst_n;
  logic [7:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [3:0]  timerMatch;
  logic        extRequestPin;
  logic        xferReq;
  logic        xferAck;
  logic [23:0] srcAddr;
  logic [23:0] dstAddr;
  logic [7:0]  ioAddr;
  logic        blockMode;
  logic        blockIsSource;
  logic [1:0]  shortMode;
  logic        endIrq;
  logic        irq;
  logic        pinPull;
  logic [1:0]  ackWait;
  int          errCount;
  int          checksDone;
  int          ackCount;

  dma_channel_control i_dut (.clock(clock), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .timerMatch(timerMatch), .serialTxEmpty(1'b0),
    .serialRxFull(1'b0), .extRequestPin(extRequestPin), .xferReq(xferReq),
    .xferAck(xferAck), .srcAddr(srcAddr), .dstAddr(dstAddr), .ioAddr(ioAddr),
    .blockMode(blockMode), .blockIsSource(blockIsSource), .shortMode(shortMode),
    .endIrq(endIrq), .irq(irq));
  bus_side_model i_far (.clock(clock), .rst_n(rst_n), .xferReq(xferReq), .xferAck(xferAck),
    .pinPull(pinPull), .ackWait(ackWait), .extRequestPin(extRequestPin));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  always @(posedge clock) begin
    if (xferReq === 1'b1 && xferAck === 1'b1) ackCount <= ackCount + 1;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checksDone++;
    if (got !== exp) begin
      errCount++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic fail(input string what);
    errCount++;
    $display("Error %s expected done seen timeout", what);
    end_sim;
  endtask

  // Settle one time unit after the edge so its updates have landed
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic avAccess(input logic wr, input logic [7:0] a, input logic [31:0] d,
                          input logic [3:0] be, output logic [31:0] q);
    int i;
    @(posedge clock);
    address    <= a;
    writedata  <= d;
    byteenable <= be;
    read       <= ~wr;
    write      <= wr;
    // Sampled before this edge's own updates land
    for (i = 0; i < 20; i++) begin
      @(posedge clock);
      if (waitrequest === 1'b0) break;
    end
    if (i == 20) fail("waitrequest");
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    avAccess(1'b1, a, d, 4'hf, q);
  endtask

  task automatic rdChk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    avAccess(1'b0, a, 32'h0000_0000, 4'hf, q);
    chk(what, exp, q);
  endtask

  task automatic waitAcks(input int n);
    int i;
    for (i = 0; i < 60 && ackCount < n; i++) tick(1);
    if (ackCount < n) fail("ackCount");
    tick(2);
  endtask

  task automatic pulse(input int k);
    @(posedge clock);
    timerMatch <= 4'h1 << k;
    @(posedge clock);
    timerMatch <= 4'h0;
    #1;
  endtask

  function automatic logic [23:0] delta(input logic en, input logic dn, input logic word);
    logic [23:0] s;
    s = word ? STEP_WORD : STEP_BYTE;
    if (!en) s = 24'h00_0000;
    else if (dn) s = -s;
    return s;
  endfunction

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    logic [31:0] q;
    rdChk("srcCtrl", IDX_SRC_CTRL, 32'h0000_0000);
    rdChk("dstCtrl", IDX_DEST_CTRL, 32'h0000_0000);
    rdChk("status", IDX_IRQ_STATUS, 32'h0000_0000);
    rdChk("srcCnt", IDX_SRC_MEM_ADDR, 32'hff00_0000);
    wr(IDX_IO_ADDR_A, 32'h0000_00a5);
    avAccess(1'b1, IDX_IO_ADDR_A, 32'h0000_003c, 4'h0, q);
    rdChk("ioA", IDX_IO_ADDR_A, 32'h0000_00a5);
    chk("ioAddr", 32'h0000_00a5, ioAddr);
    wr(IDX_IO_ADDR_B, 32'h0000_005a);
    rdChk("ioB", IDX_IO_ADDR_B, 32'h0000_005a);
    wr(IDX_DEST_MEM_ADDR, 32'habcd_ef12);
    rdChk("dstCnt", IDX_DEST_MEM_ADDR, 32'hffcd_ef12);
    wr(8'h01, 32'hffff_ffff);
    rdChk("unmapped", 8'h01, 32'h0000_0000);
    $display("t_regs finished");
  endtask

  task automatic t_short;
    int n;
    wr(IDX_MODE, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      wr(IDX_SRC_MEM_ADDR, 32'h0000_1000);
      wr(IDX_SRC_CTRL, 32'h80 | (i[0] << 6) | (i[1] << 5));
      n = ackCount;
      pulse(0);
      waitAcks(n + 1);
      chk("srcAddr", 24'(24'h1000 + delta(1'b1, i[1], i[0])), srcAddr);
    end
    wr(IDX_SRC_CTRL, 32'h0000_0000);
    n = ackCount;
    pulse(0);
    tick(5);
    chk("ackCount", n, ackCount);
    for (int j = 0; j < 4; j++) begin
      wr(IDX_SRC_CTRL, (j[1] << 4) | (j[0] << 3));
      chk("shortMode", j[1] ? (j[0] ? 2 : 1) : 0, shortMode);
      chk("endIrq", j[0], endIrq);
    end
    wr(IDX_SRC_CTRL, 32'h0000_0088);
    chk("endIrq", 0, endIrq);
    wr(IDX_SRC_CTRL, 32'h0000_0086);
    n = ackCount;
    pinPull <= 1'b1;
    waitAcks(n + 1);
    tick(8);
    chk("ackCount", n + 1, ackCount);
    pinPull <= 1'b0;
    tick(4);
    wr(IDX_SRC_CTRL, 32'h0000_0087);
    pinPull <= 1'b1;
    waitAcks(n + 4);
    pinPull <= 1'b0;
    tick(6);
    n = ackCount;
    tick(6);
    chk("ackCount", n, ackCount);
    wr(IDX_SRC_CTRL, 32'h0000_0000);
    $display("t_short finished");
  endtask

  task automatic runFull(input logic [7:0] sc, input logic [7:0] dc, input logic [1:0] w);
    int n;
    int k;
    ackWait <= w;
    wr(IDX_SRC_MEM_ADDR, 32'h0000_2000);
    wr(IDX_DEST_MEM_ADDR, 32'h0000_3000);
    wr(IDX_DEST_CTRL, dc);
    n = ackCount;
    wr(IDX_SRC_CTRL, sc);
    waitAcks(n + 3);
    wr(IDX_SRC_CTRL, 32'h0000_0000);
    tick(3);
    k = ackCount - n;
    chk("srcAddr", 24'(24'h2000 + 24'(k) * delta(sc[4], sc[5], sc[6])), srcAddr);
    chk("dstAddr", 24'(24'h3000 + 24'(k) * delta(dc[4], dc[5], sc[6])), dstAddr);
  endtask

  task automatic t_full;
    int n;
    wr(IDX_MODE, 32'h0000_0001);
    wr(IDX_DEST_CTRL, 32'h0000_0010);
    n = ackCount;
    wr(IDX_SRC_CTRL, 32'h0000_00d0);
    tick(8);
    chk("xferReq", 0, xferReq);
    chk("ackCount", n, ackCount);
    runFull(8'hd0, 8'hb0, 2'h0);
    runFull(8'hb0, 8'h82, 2'h2);
    runFull(8'hc0, 8'h90, 2'h1);
    wr(IDX_DEST_CTRL, 32'h0000_0081);
    wr(IDX_SRC_CTRL, 32'h0000_0080);
    tick(5);
    chk("xferReq", 0, xferReq);
    rdChk("status", IDX_IRQ_STATUS, 32'h0000_0003);
    wr(IDX_IRQ_MASK, 32'h0000_0002);
    chk("irq", 1, irq);
    wr(IDX_IRQ_MASK, 32'h0000_0000);
    chk("irq", 0, irq);
    wr(IDX_SRC_CTRL, 32'h0000_0000);
    $display("t_full finished");
  endtask

  task automatic t_block;
    int n;
    ackWait <= 2'h1;
    wr(IDX_IRQ_STATUS, 32'h0000_0003);
    wr(IDX_IRQ_MASK, 32'h0000_0001);
    chk("irq", 0, irq);
    wr(IDX_SRC_MEM_ADDR, 32'h0000_4000);
    wr(IDX_DEST_MEM_ADDR, 32'h0000_3000);
    for (int i = 0; i < 4; i++) begin
      wr(IDX_DEST_CTRL, 32'h80 | (i[0] << 3) | i);
      wr(IDX_SRC_CTRL, 32'h0000_0091);
      chk("blockMode", 1, blockMode);
      chk("blockIsSource", i[0], blockIsSource);
      n = ackCount;
      pulse((i + 1) % 4);
      tick(4);
      chk("ackCount", n, ackCount);
      pulse(i);
      waitAcks(n + 1);
      chk("srcAddr", 24'h4001 + i, srcAddr);
      chk("dstAddr", 24'h3000, dstAddr);
    end
    wr(IDX_DEST_CTRL, 32'h0000_0086);
    n = ackCount;
    pinPull <= 1'b1;
    waitAcks(n + 1);
    tick(6);
    chk("ackCount", n + 1, ackCount);
    pinPull <= 1'b0;
    wr(IDX_DEST_CTRL, 32'h0000_0087);
    tick(4);
    chk("xferReq", 0, xferReq);
    rdChk("status", IDX_IRQ_STATUS, 32'h0000_0003);
    chk("irq", 1, irq);
    wr(IDX_IRQ_MASK, 32'h0000_0000);
    chk("irq", 0, irq);
    wr(IDX_IRQ_MASK, 32'h0000_0001);
    wr(IDX_SRC_CTRL, 32'h0000_0000);
    wr(IDX_IRQ_STATUS, 32'h0000_0003);
    chk("irq", 0, irq);
    rdChk("status", IDX_IRQ_STATUS, 32'h0000_0000);
    $display("t_block finished");
  endtask

  initial begin
    rst_n = 1'b0;
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0000_0000;
    byteenable = 4'hf;
    timerMatch = 4'h0;
    pinPull = 1'b0;
    ackWait = 2'h0;
    errCount = 0;
    checksDone = 0;
    ackCount = 0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    t_regs;
    t_short;
    t_full;
    t_block;
    end_sim;
  end
endmodule

// >>> hdl/dma_channel_control.sv
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ps
// How it works
// - End interrupt raised while enable bit clear
// - Short mode, direction 0: counter counts up
// - Short mode, direction 1: counter counts down
// - Transfers happen only while enable bit set
// - Full normal mode select code decoding
// - Full block mode select code decoding
// - Block side bit chooses block area
// - Destination counter fixed or stepped per direction
// - Full mode master enable gates transfers
// - Same bit functions as first channel
// - Source counter fixed or stepped per direction
// - Short mode external pin edge/level starts
module dma_channel_control
  import dma_channel_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Avalon-MM slave
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // Activation sources
  input  wire logic [3:0]  timerMatch,
  input  wire logic        serialTxEmpty,
  input  wire logic        serialRxFull,
  input  wire logic        extRequestPin,
  // Transfer handshake to the bus side
  output logic             xferReq,
  input  wire logic        xferAck,
  output logic [23:0]      srcAddr,
  output logic [23:0]      dstAddr,
  output logic [7:0]       ioAddr,
  output logic             blockMode,
  output logic             blockIsSource,
  output logic [1:0]       shortMode,
  // Interrupts
  output logic             endIrq,
  output logic             irq
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [23:0] srcCnt_q;
  logic [23:0] dstCnt_q;
  logic [7:0]  srcCtrl_q;
  logic [7:0]  dstCtrl_q;
  logic [7:0]  ioA_q;
  logic [7:0]  ioB_q;
  logic [1:0]  status_q;
  logic [1:0]  mask_q;
  logic        fullMode_q;
  logic        resp_q;
  logic [31:0] rdata_q;
  logic        extMeta_q;
  logic        extSync_q;
  logic        extPrev_q;
  logic        pending_q;
  logic        gap_q;

  logic        busDone;
  logic        wrDone;
  logic        xferDone;
  logic        enabled;
  logic [2:0]  sel;
  logic        levelReq;
  logic        edgeReq;
  logic        badSel;
  logic        extFall;
  logic [31:0] rdata_d;

  // ----------------------------------------------------------------
  // Bus slave: one wait state on every access
  // ----------------------------------------------------------------
  assign waitrequest = (read | write) & ~resp_q;
  assign busDone     = (read | write) & resp_q;
  assign wrDone      = write & resp_q;
  assign readdata    = rdata_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      resp_q <= 1'b0;
    end else begin
      resp_q <= (read | write) & ~resp_q;
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    case (address)
      IDX_SRC_MEM_ADDR:  rdata_d = {ADDR_TOP, srcCnt_q};
      IDX_DEST_MEM_ADDR: rdata_d = {ADDR_TOP, dstCnt_q};
      IDX_SRC_CTRL:      rdata_d[7:0] = srcCtrl_q;
      IDX_DEST_CTRL:     rdata_d[7:0] = dstCtrl_q;
      IDX_IO_ADDR_A:     rdata_d[7:0] = ioA_q;
      IDX_IO_ADDR_B:     rdata_d[7:0] = ioB_q;
      IDX_IRQ_STATUS:    rdata_d[1:0] = status_q;
      IDX_IRQ_MASK:      rdata_d[1:0] = mask_q;
      IDX_MODE:          rdata_d[MODE_FULL_BIT] = fullMode_q;
      default:           rdata_d = 32'h0000_0000;
    endcase
  end

  // Captured in the wait cycle, stands at the completing edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (read && !resp_q) begin
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      srcCtrl_q  <= CTRL_RESET;
      dstCtrl_q  <= CTRL_RESET;
      ioA_q      <= CTRL_RESET;
      ioB_q      <= CTRL_RESET;
      mask_q     <= STAT_RESET;
      fullMode_q <= 1'b0;
    end else if (wrDone && byteenable[0]) begin
      case (address)
        IDX_SRC_CTRL:  srcCtrl_q  <= writedata[7:0];
        IDX_DEST_CTRL: dstCtrl_q  <= writedata[7:0];
        IDX_IO_ADDR_A: ioA_q      <= writedata[7:0];
        IDX_IO_ADDR_B: ioB_q      <= writedata[7:0];
        IDX_IRQ_MASK:  mask_q     <= writedata[1:0];
        IDX_MODE:      fullMode_q <= writedata[MODE_FULL_BIT];
        default:       ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Enables and sub-modes
  // ----------------------------------------------------------------
  always_comb begin
    if (fullMode_q) begin
      enabled = srcCtrl_q[XFER_ENABLE_BIT] & dstCtrl_q[MASTER_ENABLE_BIT];
    end else begin
      enabled = srcCtrl_q[XFER_ENABLE_BIT];
    end
  end

  assign endIrq        = srcCtrl_q[END_IRQ_ENABLE_BIT] & ~srcCtrl_q[XFER_ENABLE_BIT];
  assign blockMode     = fullMode_q & srcCtrl_q[BLOCK_MODE_BIT];
  assign blockIsSource = blockMode & dstCtrl_q[BLOCK_SIDE_BIT];
  assign srcAddr       = srcCnt_q;
  assign dstAddr       = dstCnt_q;
  assign ioAddr        = ioA_q;

  always_comb begin
    if (!srcCtrl_q[REPEAT_SELECT_BIT]) begin
      shortMode = SHORT_IO;
    end else if (!srcCtrl_q[END_IRQ_ENABLE_BIT]) begin
      shortMode = SHORT_REPEAT;
    end else begin
      shortMode = SHORT_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // External request pin: synchroniser and edge detect
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      extMeta_q <= 1'b1;
      extSync_q <= 1'b1;
      extPrev_q <= 1'b1;
    end else begin
      extMeta_q <= extRequestPin;
      extSync_q <= extMeta_q;
      extPrev_q <= extSync_q;
    end
  end

  assign extFall = extPrev_q & ~extSync_q;

  // ----------------------------------------------------------------
  // Activation source decode
  // ----------------------------------------------------------------
  assign sel = fullMode_q ? dstCtrl_q[2:0] : srcCtrl_q[2:0];

  always_comb begin
    levelReq = 1'b0;
    edgeReq  = 1'b0;
    badSel   = 1'b0;
    if (!fullMode_q) begin
      case (sel)
        SEL_SER_TX:   levelReq = serialTxEmpty;
        SEL_SER_RX:   levelReq = serialRxFull;
        SEL_EXT_FALL: edgeReq  = extFall;
        SEL_EXT_LOW:  levelReq = ~extSync_q;
        default:      edgeReq  = timerMatch[sel[1:0]];
      endcase
    end else if (blockMode) begin
      case (sel)
        SEL_EXT_FALL: edgeReq = extFall;
        SEL_SER_TX,
        SEL_SER_RX,
        SEL_EXT_LOW:  badSel  = 1'b1;
        default:      edgeReq = timerMatch[sel[1:0]];
      endcase
    end else begin
      case (sel)
        SEL_BURST:      levelReq = 1'b1;
        SEL_CYCLESTEAL: levelReq = ~gap_q;
        SEL_EXT_FALL:   edgeReq  = extFall;
        SEL_EXT_LOW:    levelReq = ~extSync_q;
        default:        badSel   = 1'b1;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Request and handshake
  // ----------------------------------------------------------------
  assign xferReq  = enabled & ~badSel & (pending_q | levelReq);
  assign xferDone = xferReq & xferAck;

  // Edges are remembered so a short pulse is not lost while busy
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pending_q <= 1'b0;
      gap_q     <= 1'b0;
    end else begin
      gap_q <= xferDone;
      if (!enabled) begin
        pending_q <= 1'b0;
      end else if (edgeReq && !badSel) begin
        pending_q <= 1'b1;
      end else if (xferDone) begin
        pending_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Address counters
  // ----------------------------------------------------------------
  function automatic logic [23:0] stepAddr(input logic [23:0] a,
                                           input logic        down,
                                           input logic        word);
    logic [23:0] s;
    s = word ? STEP_WORD : STEP_BYTE;
    return down ? a - s : a + s;
  endfunction

  function automatic logic [23:0] busMerge(input logic [23:0] a);
    logic [23:0] r;
    r = a;
    if (byteenable[0]) r[7:0]   = writedata[7:0];
    if (byteenable[1]) r[15:8]  = writedata[15:8];
    if (byteenable[2]) r[23:16] = writedata[23:16];
    return r;
  endfunction

  // Software write takes priority over a same-cycle step
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      srcCnt_q <= ADDR_RESET;
    end else if (wrDone && address == IDX_SRC_MEM_ADDR) begin
      srcCnt_q <= busMerge(srcCnt_q);
    end else if (xferDone) begin
      if (!fullMode_q) begin
        srcCnt_q <= stepAddr(srcCnt_q, srcCtrl_q[ADDR_DIRECTION_BIT],
                             srcCtrl_q[XFER_SIZE_WORD_BIT]);
      end else if (srcCtrl_q[SRC_STEP_EN_BIT]) begin
        srcCnt_q <= stepAddr(srcCnt_q, srcCtrl_q[ADDR_DIRECTION_BIT],
                             srcCtrl_q[XFER_SIZE_WORD_BIT]);
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dstCnt_q <= ADDR_RESET;
    end else if (wrDone && address == IDX_DEST_MEM_ADDR) begin
      dstCnt_q <= busMerge(dstCnt_q);
    end else if (xferDone && fullMode_q && dstCtrl_q[DEST_STEP_EN_BIT]) begin
      dstCnt_q <= stepAddr(dstCnt_q, dstCtrl_q[DEST_DIR_BIT],
                           srcCtrl_q[XFER_SIZE_WORD_BIT]);
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status: write one to clear, set wins
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= STAT_RESET;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == STAT_DONE_BIT && xferDone) ||
            (i == STAT_BADSEL_BIT && badSel && enabled)) begin
          status_q[i] <= 1'b1;
        end else if (wrDone && byteenable[0] && address == IDX_IRQ_STATUS &&
                     writedata[i]) begin
          status_q[i] <= 1'b0;
        end
      end
    end
  end

  assign irq = |(status_q & mask_q);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_end_irq_level: assert property (@(posedge clock) disable iff (!rst_n)
    srcCtrl_q[END_IRQ_ENABLE_BIT] && !srcCtrl_q[XFER_ENABLE_BIT] |-> endIrq)
    else $error("end interrupt missing while enable clear");

  a_no_req_disabled: assert property (@(posedge clock) disable iff (!rst_n)
    !srcCtrl_q[XFER_ENABLE_BIT] |-> !xferReq)
    else $error("request while transfer disabled");

  a_short_step_up: assert property (@(posedge clock) disable iff (!rst_n)
    xferDone && !fullMode_q && !srcCtrl_q[ADDR_DIRECTION_BIT] &&
    !(wrDone && address == IDX_SRC_MEM_ADDR)
    |=> srcCnt_q == $past(srcCnt_q) + ($past(srcCtrl_q[XFER_SIZE_WORD_BIT]) ? 24'd2 : 24'd1))
    else $error("short mode counter did not step up");

  a_short_step_down: assert property (@(posedge clock) disable iff (!rst_n)
    xferDone && !fullMode_q && srcCtrl_q[ADDR_DIRECTION_BIT] &&
    !(wrDone && address == IDX_SRC_MEM_ADDR)
    |=> srcCnt_q == $past(srcCnt_q) - ($past(srcCtrl_q[XFER_SIZE_WORD_BIT]) ? 24'd2 : 24'd1))
    else $error("short mode counter did not step down");

  a_burst_request: assert property (@(posedge clock) disable iff (!rst_n)
    fullMode_q && !blockMode && sel == SEL_BURST && enabled |-> xferReq)
    else $error("burst auto-request not raised");

  a_block_badcode: assert property (@(posedge clock) disable iff (!rst_n)
    blockMode && sel == SEL_EXT_LOW |-> !xferReq)
    else $error("request on unavailable block code");

  a_block_side: assert property (@(posedge clock) disable iff (!rst_n)
    blockIsSource |-> blockMode && dstCtrl_q[BLOCK_SIDE_BIT])
    else $error("block side wrong");

  a_dest_fixed: assert property (@(posedge clock) disable iff (!rst_n)
    xferDone && !dstCtrl_q[DEST_STEP_EN_BIT] && !wrDone |=> $stable(dstCnt_q))
    else $error("destination counter moved while fixed");

  a_master_gate: assert property (@(posedge clock) disable iff (!rst_n)
    fullMode_q && !dstCtrl_q[MASTER_ENABLE_BIT] |-> !xferReq)
    else $error("request with master enable clear");

  a_src_fixed: assert property (@(posedge clock) disable iff (!rst_n)
    xferDone && fullMode_q && !srcCtrl_q[SRC_STEP_EN_BIT] && !wrDone |=> $stable(srcCnt_q))
    else $error("source counter moved while fixed");

  a_ext_fall_req: assert property (@(posedge clock) disable iff (!rst_n)
    !fullMode_q && sel == SEL_EXT_FALL && enabled && extFall |=> xferReq || !enabled)
    else $error("falling edge did not request");

  a_idle_mode: assert property (@(posedge clock) disable iff (!rst_n)
    srcCtrl_q[REPEAT_SELECT_BIT] && srcCtrl_q[END_IRQ_ENABLE_BIT] |-> shortMode == SHORT_IDLE)
    else $error("sub-mode not idle");

  a_bus_wait_one: assert property (@(posedge clock) disable iff (!rst_n)
    (read || write) && !resp_q |=> !waitrequest)
    else $error("access took more than one wait state");

endmodule

// >>> hdl/dma_channel_pkg.sv
package dma_channel_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_SRC_MEM_ADDR  = 8'h30;
  localparam logic [7:0] IDX_SRC_CTRL      = 8'h34;
  localparam logic [7:0] IDX_IO_ADDR_A     = 8'h36;
  localparam logic [7:0] IDX_DEST_MEM_ADDR = 8'h38;
  localparam logic [7:0] IDX_DEST_CTRL     = 8'h3c;
  localparam logic [7:0] IDX_IO_ADDR_B     = 8'h3e;
  localparam logic [7:0] IDX_IRQ_STATUS    = 8'h40;
  localparam logic [7:0] IDX_IRQ_MASK      = 8'h41;
  localparam logic [7:0] IDX_MODE          = 8'h42;

  // ----------------------------------------------------------------
  // Source-side control fields
  // ----------------------------------------------------------------
  localparam int XFER_ENABLE_BIT    = 7;
  localparam int XFER_SIZE_WORD_BIT = 6;
  localparam int ADDR_DIRECTION_BIT = 5;
  localparam int REPEAT_SELECT_BIT  = 4;
  localparam int SRC_STEP_EN_BIT    = 4;
  localparam int END_IRQ_ENABLE_BIT = 3;
  localparam int BLOCK_MODE_BIT     = 0;

  // ----------------------------------------------------------------
  // Destination-side control fields
  // ----------------------------------------------------------------
  localparam int MASTER_ENABLE_BIT  = 7;
  localparam int DEST_DIR_BIT       = 5;
  localparam int DEST_STEP_EN_BIT   = 4;
  localparam int BLOCK_SIDE_BIT     = 3;

  // ----------------------------------------------------------------
  // Status bits, mode bit, reset values
  // ----------------------------------------------------------------
  localparam int STAT_DONE_BIT      = 0;
  localparam int STAT_BADSEL_BIT    = 1;
  localparam int MODE_FULL_BIT      = 0;
  localparam logic [7:0]  CTRL_RESET  = 8'h00;
  localparam logic [23:0] ADDR_RESET  = 24'h00_0000;
  localparam logic [7:0]  ADDR_TOP    = 8'hff;
  localparam logic [1:0]  STAT_RESET  = 2'h0;

  // ----------------------------------------------------------------
  // Activation select codes
  // ----------------------------------------------------------------
  localparam logic [2:0] SEL_BURST      = 3'h0;
  localparam logic [2:0] SEL_CYCLESTEAL = 3'h2;
  localparam logic [2:0] SEL_SER_TX     = 3'h4;
  localparam logic [2:0] SEL_SER_RX     = 3'h5;
  localparam logic [2:0] SEL_EXT_FALL   = 3'h6;
  localparam logic [2:0] SEL_EXT_LOW    = 3'h7;

  // Short address sub-modes
  localparam logic [1:0] SHORT_IO     = 2'h0;
  localparam logic [1:0] SHORT_REPEAT = 2'h1;
  localparam logic [1:0] SHORT_IDLE   = 2'h2;

  // Address steps
  localparam logic [23:0] STEP_BYTE = 24'h00_0001;
  localparam logic [23:0] STEP_WORD = 24'h00_0002;

endpackage
